//--- hw/pdc_pkg.sv
// Package for the power-down and clock-select block: offsets, fields, types.
package pdc_pkg;

	// Register map, byte addresses, 32-bit aligned words
	localparam logic [7:0] PDC_OFF_PMCC  = 8'h00;
	localparam logic [7:0] PDC_OFF_MSB1  = 8'h04;
	localparam logic [7:0] PDC_OFF_MSB2  = 8'h08;
	localparam logic [7:0] PDC_OFF_SYSC  = 8'h0C;
	localparam logic [7:0] PDC_OFF_STAT  = 8'h10;

	// Power mode / clock control fields
	localparam int PDC_SLEEP_KIND_BIT    = 7;
	localparam int PDC_LOW_SPEED_BIT     = 6;
	localparam int PDC_DIRECT_BIT        = 5;
	localparam int PDC_ACT_DIV_LSB       = 2;
	localparam int PDC_SUB_DIV_LSB       = 0;

	// Standby-select bit in the companion register
	localparam int PDC_STANDBY_SEL_BIT   = 7;

	// Writable masks; cleared positions are reserved and read zero
	localparam logic [7:0] PDC_MSB1_MASK = 8'h7B;
	localparam logic [7:0] PDC_MSB2_MASK = 8'h93;
	localparam logic [7:0] PDC_RESET_VAL = 8'h00;

	// Standby bit positions
	localparam int PDC_TWOWIRE_BIT   = 6;
	localparam int PDC_SERIAL_A_BIT  = 5;
	localparam int PDC_ADC_BIT       = 4;
	localparam int PDC_WDOG_BIT      = 3;
	localparam int PDC_TIMER_V_BIT   = 1;
	localparam int PDC_RTC_BIT       = 0;
	localparam int PDC_SERIAL_B_BIT  = 7;
	localparam int PDC_TIMER_B_BIT   = 4;
	localparam int PDC_TIMER_Z_BIT   = 1;
	localparam int PDC_PWM_BIT       = 0;

	// Divider: select codes, then log2 of each divide ratio
	localparam logic [2:0] PDC_ACT_DIV8  = 3'h4;
	localparam logic [2:0] PDC_ACT_DIV16 = 3'h5;
	localparam logic [2:0] PDC_ACT_DIV32 = 3'h6;
	localparam logic [2:0] PDC_ACT_DIV64 = 3'h7;
	localparam logic [1:0] PDC_SUB_DIV8  = 2'h0;
	localparam logic [1:0] PDC_SUB_DIV4  = 2'h1;
	localparam logic [2:0] PDC_LOG_1     = 3'h0;
	localparam logic [2:0] PDC_LOG_2     = 3'h1;
	localparam logic [2:0] PDC_LOG_4     = 3'h2;
	localparam logic [2:0] PDC_LOG_8     = 3'h3;
	localparam logic [2:0] PDC_LOG_16    = 3'h4;
	localparam logic [2:0] PDC_LOG_32    = 3'h5;
	localparam logic [2:0] PDC_LOG_64    = 3'h6;

	// Operating modes
	typedef enum logic [2:0] {
		PDC_ACTIVE,
		PDC_SLEEP,
		PDC_SUBACTIVE,
		PDC_SUBSLEEP,
		PDC_STANDBY
	} pdc_mode_t;

	// Register bus request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} pdc_bus_req_t;

	// Per-module standby outputs
	typedef struct packed {
		logic twowire;
		logic serial_a;
		logic adc;
		logic watchdog;
		logic timer_v;
		logic rtc;
		logic serial_b;
		logic timer_b;
		logic timer_z;
		logic pwm;
	} pdc_standby_t;

	// Whole block state
	typedef struct packed {
		logic [7:0]  pmcc;
		logic [7:0]  msb1;
		logic [7:0]  msb2;
		logic        standby_sel;
		logic [2:0]  act_div_live;
		logic [1:0]  sub_div_live;
		pdc_mode_t   mode;
		logic [31:0] rdata;
		logic [5:0]  div_cnt;
		logic        clk_en;
	} pdc_state_t;

endpackage

//--- hw/pdc_power_clock.sv
// Power-down mode select, clock divider select and module standby control.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module pdc_power_clock (
	// Clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  rst_n_i,
	// Register bus
	input  wire pdc_pkg::pdc_bus_req_t bus_i,
	output logic [31:0]                rdata_o,
	// Processor events
	input  wire logic                  sleep_exec_i,
	input  wire logic                  irq_wake_i,
	input  wire logic                  wdog_int_osc_i,
	// Mode and clocks
	output pdc_pkg::pdc_mode_t         mode_o,
	output logic                       cpu_halt_o,
	output logic                       clk_en_o,
	output logic                       main_osc_on_o,
	output logic [2:0]                 act_log2_o,
	output logic [2:0]                 sub_log2_o,
	// Module standby
	output pdc_pkg::pdc_standby_t      standby_o
);
	import pdc_pkg::*;

	pdc_state_t s_r;
	pdc_state_t s_nxt;
	logic [2:0] act_log2;
	logic [2:0] sub_log2;
	logic [2:0] cur_log2;
	logic [5:0] div_top;

	// Divide ratio of live settings, as log2
	always_comb begin
		unique case (s_r.act_div_live)
			PDC_ACT_DIV8:  act_log2 = PDC_LOG_8;
			PDC_ACT_DIV16: act_log2 = PDC_LOG_16;
			PDC_ACT_DIV32: act_log2 = PDC_LOG_32;
			PDC_ACT_DIV64: act_log2 = PDC_LOG_64;
			default:       act_log2 = PDC_LOG_1;   // Codes 0XX run undivided
		endcase
		if (s_r.sub_div_live == PDC_SUB_DIV8) begin
			sub_log2 = PDC_LOG_8;
		end else if (s_r.sub_div_live == PDC_SUB_DIV4) begin
			sub_log2 = PDC_LOG_4;
		end else begin
			sub_log2 = PDC_LOG_2;
		end
		cur_log2 = (s_r.mode == PDC_SUBACTIVE || s_r.mode == PDC_SUBSLEEP) ? sub_log2 : act_log2;
		div_top  = 6'((7'h01 << cur_log2) - 7'h01);
	end

	// Next state: registers, mode sequencing, divider
	always_comb begin
		logic [7:0] rd_byte;
		rd_byte = 8'h00;
		s_nxt = s_r;
		// Register writes; reserved bits masked so they read zero
		if (bus_i.wr) begin
			unique case (bus_i.addr)
				PDC_OFF_PMCC: s_nxt.pmcc = bus_i.wdata[7:0];
				PDC_OFF_MSB1: s_nxt.msb1 = bus_i.wdata[7:0] & PDC_MSB1_MASK;
				PDC_OFF_MSB2: s_nxt.msb2 = bus_i.wdata[7:0] & PDC_MSB2_MASK;
				PDC_OFF_SYSC: s_nxt.standby_sel = bus_i.wdata[PDC_STANDBY_SEL_BIT];
				default:      s_nxt.pmcc = s_r.pmcc;   // Unmapped writes ignored
			endcase
		end
		// Read data stands only in the cycle after the strobe
		if (bus_i.rd) begin
			unique case (bus_i.addr)
				PDC_OFF_PMCC: rd_byte = s_r.pmcc;
				PDC_OFF_MSB1: rd_byte = s_r.msb1;
				PDC_OFF_MSB2: rd_byte = s_r.msb2;
				PDC_OFF_SYSC: rd_byte = {s_r.standby_sel, 7'h00};
				PDC_OFF_STAT: rd_byte = {5'h00, s_r.mode};
				default:      rd_byte = 8'h00;         // Unmapped reads zero
			endcase
		end
		s_nxt.rdata = {24'h00_0000, rd_byte};
		// Sleep instruction: mode change, dividers latched here
		if (sleep_exec_i && (s_r.mode == PDC_ACTIVE || s_r.mode == PDC_SUBACTIVE)) begin
			s_nxt.act_div_live = s_r.pmcc[PDC_ACT_DIV_LSB +: 3];
			s_nxt.sub_div_live = s_r.pmcc[PDC_SUB_DIV_LSB +: 2];
			if (s_r.pmcc[PDC_DIRECT_BIT]) begin
				// No halt: jump straight between run modes
				s_nxt.mode = s_r.pmcc[PDC_LOW_SPEED_BIT] ? PDC_SUBACTIVE : PDC_ACTIVE;
			end else if (s_r.standby_sel) begin
				s_nxt.mode = PDC_STANDBY;
			end else if (s_r.pmcc[PDC_SLEEP_KIND_BIT]) begin
				s_nxt.mode = PDC_SUBSLEEP;
			end else begin
				s_nxt.mode = PDC_SLEEP;
			end
		end else if (irq_wake_i && (s_r.mode == PDC_SLEEP || s_r.mode == PDC_SUBSLEEP)) begin
			s_nxt.mode = s_r.pmcc[PDC_LOW_SPEED_BIT] ? PDC_SUBACTIVE : PDC_ACTIVE;
		end else if (irq_wake_i && s_r.mode == PDC_STANDBY) begin
			s_nxt.mode = PDC_ACTIVE;
		end
		// Clock enable divider; restarts on any mode change to avoid a runt
		if (s_nxt.mode != s_r.mode || s_r.div_cnt >= div_top) begin
			s_nxt.div_cnt = 6'h00;
		end else begin
			s_nxt.div_cnt = s_r.div_cnt + 6'h01;
		end
		// Gate on the coming mode, so no pulse slips out on the way into standby
		s_nxt.clk_en = (s_nxt.mode != PDC_STANDBY) && (s_r.div_cnt >= div_top);
	end

	// State register; reset clears every control bit
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
			s_r.mode <= PDC_ACTIVE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs
	assign rdata_o       = s_r.rdata;
	assign mode_o        = s_r.mode;
	assign cpu_halt_o    = (s_r.mode == PDC_SLEEP) || (s_r.mode == PDC_SUBSLEEP) ||
	                       (s_r.mode == PDC_STANDBY);
	assign clk_en_o      = s_r.clk_en;
	assign main_osc_on_o = (s_r.mode == PDC_ACTIVE) || (s_r.mode == PDC_SLEEP);
	assign act_log2_o    = act_log2;
	assign sub_log2_o    = sub_log2;

	// Module standby decode
	assign standby_o.twowire  = s_r.msb1[PDC_TWOWIRE_BIT];
	assign standby_o.serial_a = s_r.msb1[PDC_SERIAL_A_BIT];
	assign standby_o.adc      = s_r.msb1[PDC_ADC_BIT];
	// Internal oscillator keeps the watchdog counting
	assign standby_o.watchdog = s_r.msb1[PDC_WDOG_BIT] && !wdog_int_osc_i;
	assign standby_o.timer_v  = s_r.msb1[PDC_TIMER_V_BIT];
	assign standby_o.rtc      = s_r.msb1[PDC_RTC_BIT];
	assign standby_o.serial_b = s_r.msb2[PDC_SERIAL_B_BIT];
	assign standby_o.timer_b  = s_r.msb2[PDC_TIMER_B_BIT];
	assign standby_o.timer_z  = s_r.msb2[PDC_TIMER_Z_BIT];
	assign standby_o.pwm      = s_r.msb2[PDC_PWM_BIT];

	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	// Sleep instruction that the sequencer will act on
	logic run_sleep;
	assign run_sleep = sleep_exec_i && (mode_o == PDC_ACTIVE || mode_o == PDC_SUBACTIVE);

	// Named steps; booleans inside properties use the plain signal
	sequence run_sleep_s;
		run_sleep;
	endsequence

	// Wake request while the processor is halted
	sequence halt_wake_s;
		irq_wake_i && cpu_halt_o;
	endsequence

	// Write of the first standby register
	sequence wr_msb1_s;
		bus_i.wr && bus_i.addr == PDC_OFF_MSB1;
	endsequence

	// Write of the second standby register
	sequence wr_msb2_s;
		bus_i.wr && bus_i.addr == PDC_OFF_MSB2;
	endsequence

	// Reset values show at the first edge after release
	reset_clear_a: assert property (!$past(rst_n_i) |-> mode_o == PDC_ACTIVE &&
		standby_o == '0 && act_log2_o == PDC_LOG_1 && sub_log2_o == PDC_LOG_8 &&
		!clk_en_o && rdata_o == 32'h0000_0000) else $error("reset values wrong");

	// Standby select wins over the sleep kinds, but not over direct transfer
	standby_entry_a: assert property (run_sleep && !s_r.pmcc[PDC_DIRECT_BIT] && s_r.standby_sel
		|=> mode_o == PDC_STANDBY) else $error("standby not entered");

	// Sleep kind set, both flags clear: subsleep
	sleep_kind_a: assert property (run_sleep && s_r.pmcc[7:5] == 3'h4 && !s_r.standby_sel
		|=> mode_o == PDC_SUBSLEEP) else $error("subsleep not entered");

	// Sleep kind set with low speed: still subsleep
	subsleep_low_a: assert property (run_sleep && s_r.pmcc[7:5] == 3'h6 && !s_r.standby_sel
		|=> mode_o == PDC_SUBSLEEP) else $error("subsleep low not entered");

	// All three flags clear: plain sleep
	sleep_plain_a: assert property (run_sleep && s_r.pmcc[7:5] == 3'h0 && !s_r.standby_sel
		|=> mode_o == PDC_SLEEP) else $error("sleep not entered");

	// Low speed alone still halts in sleep, wake picks subactive
	sleep_low_a: assert property (run_sleep && s_r.pmcc[7:5] == 3'h2 && !s_r.standby_sel
		|=> mode_o == PDC_SLEEP) else $error("sleep low not entered");

	// Sleep strobes while halted must not move the mode
	halt_ignore_a: assert property (cpu_halt_o && !irq_wake_i
		|=> $stable(mode_o)) else $error("halted mode moved");

	// Run modes only move on a sleep instruction
	run_ignore_a: assert property (!cpu_halt_o && !sleep_exec_i
		|=> $stable(mode_o)) else $error("run mode moved");

	// Direct transfer never halts the processor
	direct_move_a: assert property (run_sleep && s_r.pmcc[PDC_DIRECT_BIT]
		|=> !cpu_halt_o) else $error("direct transfer halted");

	// Direct transfer with low speed clear lands in active
	direct_act_a: assert property (run_sleep && s_r.pmcc[PDC_DIRECT_BIT] &&
		!s_r.pmcc[PDC_LOW_SPEED_BIT] |=> mode_o == PDC_ACTIVE)
		else $error("direct transfer not active");

	// Direct transfer with low speed set lands in subactive
	direct_sub_a: assert property (run_sleep && s_r.pmcc[PDC_DIRECT_BIT] &&
		s_r.pmcc[PDC_LOW_SPEED_BIT] |=> mode_o == PDC_SUBACTIVE)
		else $error("direct transfer not subactive");

	// Standby select is ignored while direct transfer is set
	direct_wins_a: assert property (run_sleep && s_r.pmcc[PDC_DIRECT_BIT] && s_r.standby_sel
		|=> mode_o != PDC_STANDBY) else $error("direct transfer entered standby");

	// Standby always wakes to active
	standby_wake_a: assert property (mode_o == PDC_STANDBY && irq_wake_i
		|=> mode_o == PDC_ACTIVE) else $error("standby wake not active");

	// Sleep or subsleep wake with low speed clear goes active
	halt_wake_a: assert property (halt_wake_s and (mode_o != PDC_STANDBY &&
		!s_r.pmcc[PDC_LOW_SPEED_BIT]) |=> mode_o == PDC_ACTIVE)
		else $error("wake not active");

	// Sleep or subsleep wake with low speed set goes subactive
	halt_wake_sub_a: assert property (halt_wake_s and (mode_o != PDC_STANDBY &&
		s_r.pmcc[PDC_LOW_SPEED_BIT]) |=> mode_o == PDC_SUBACTIVE)
		else $error("wake not subactive");

	// Standby keeps the divided clock quiet
	standby_quiet_a: assert property (mode_o == PDC_STANDBY
		|-> !clk_en_o) else $error("clock pulse in standby");

	// Divided pulse is one cycle wide once the ratio is above one
	pulse_width_a: assert property (clk_en_o && mode_o == PDC_ACTIVE && !run_sleep &&
		act_log2_o != PDC_LOG_1 |=> !clk_en_o) else $error("clock pulse too wide");

	// A written divider code waits for the sleep instruction
	act_hold_a: assert property (!run_sleep && $changed(s_r.pmcc[4:2])
		|=> $stable(act_log2_o)) else $error("active divider changed early");

	// Without a sleep the live active ratio never moves
	act_idle_a: assert property (!run_sleep
		|=> $stable(act_log2_o)) else $error("active divider moved");

	// A written subactive code waits for the sleep instruction
	sub_hold_a: assert property (!run_sleep && $changed(s_r.pmcc[1:0])
		|=> $stable(sub_log2_o)) else $error("subactive divider changed early");

	// Without a sleep the live subactive ratio never moves
	sub_idle_a: assert property (!run_sleep
		|=> $stable(sub_log2_o)) else $error("subactive divider moved");

	// Subactive ratio after a sleep follows the code written before it
	sub_apply_a: assert property (run_sleep_s |=> sub_log2_o == ($past(s_r.pmcc[1]) ?
		PDC_LOG_2 : ($past(s_r.pmcc[0]) ? PDC_LOG_4 : PDC_LOG_8)))
		else $error("subactive divider wrong");

	// Code 00 divides the watch clock by 8
	sub_div8_a: assert property (run_sleep_s and (s_r.pmcc[1:0] == 2'h0)
		|=> sub_log2_o == PDC_LOG_8) else $error("subactive divide by 8 wrong");

	// Code 01 divides the watch clock by 4
	sub_div4_a: assert property (run_sleep_s and (s_r.pmcc[1:0] == 2'h1)
		|=> sub_log2_o == PDC_LOG_4) else $error("subactive divide by 4 wrong");

	// Codes 1X divide the watch clock by 2
	sub_div2_a: assert property (run_sleep_s and (s_r.pmcc[1])
		|=> sub_log2_o == PDC_LOG_2) else $error("subactive divide by 2 wrong");

	// Codes 0XX run the active clock undivided
	act_undiv_a: assert property (run_sleep_s and (!s_r.pmcc[4])
		|=> act_log2_o == PDC_LOG_1) else $error("undivided not applied");

	// Code 100 divides by 8
	act_div8_a: assert property (run_sleep_s and (s_r.pmcc[4:2] == 3'h4)
		|=> act_log2_o == PDC_LOG_8) else $error("divide by 8 not applied");

	// Code 101 divides by 16
	act_div16_a: assert property (run_sleep_s and (s_r.pmcc[4:2] == 3'h5)
		|=> act_log2_o == PDC_LOG_16) else $error("divide by 16 not applied");

	// Code 110 divides by 32
	act_div32_a: assert property (run_sleep_s and (s_r.pmcc[4:2] == 3'h6)
		|=> act_log2_o == PDC_LOG_32) else $error("divide by 32 not applied");

	// Code 111 divides by 64
	act_div64_a: assert property (run_sleep && s_r.pmcc[4:2] == 3'h7
		|=> act_log2_o == PDC_LOG_64) else $error("divide by 64 not applied");

	// Standby outputs follow the written bits one cycle later; the watchdog one only while wdog_int_osc_i is low
	twowire_sb_a: assert property (wr_msb1_s |=> standby_o.twowire ==
		$past(bus_i.wdata[PDC_TWOWIRE_BIT])) else $error("two-wire standby wrong");
	serial_a_sb_a: assert property (wr_msb1_s |=> standby_o.serial_a ==
		$past(bus_i.wdata[PDC_SERIAL_A_BIT])) else $error("serial A standby wrong");
	adc_sb_a: assert property (wr_msb1_s |=> standby_o.adc ==
		$past(bus_i.wdata[PDC_ADC_BIT])) else $error("converter standby wrong");
	wdog_sb_a: assert property (wr_msb1_s |=> standby_o.watchdog ==
		($past(bus_i.wdata[PDC_WDOG_BIT]) && !wdog_int_osc_i)) else $error("watchdog standby wrong");
	timer_v_sb_a: assert property (wr_msb1_s |=> standby_o.timer_v ==
		$past(bus_i.wdata[PDC_TIMER_V_BIT])) else $error("timer V standby wrong");
	rtc_sb_a: assert property (wr_msb1_s |=> standby_o.rtc ==
		$past(bus_i.wdata[PDC_RTC_BIT])) else $error("clock standby wrong");
	serial_b_sb_a: assert property (wr_msb2_s |=> standby_o.serial_b ==
		$past(bus_i.wdata[PDC_SERIAL_B_BIT])) else $error("serial B standby wrong");
	timer_b_sb_a: assert property (wr_msb2_s |=> standby_o.timer_b ==
		$past(bus_i.wdata[PDC_TIMER_B_BIT])) else $error("timer B standby wrong");
	timer_z_sb_a: assert property (wr_msb2_s |=> standby_o.timer_z ==
		$past(bus_i.wdata[PDC_TIMER_Z_BIT])) else $error("timer Z standby wrong");
	pwm_sb_a: assert property (wr_msb2_s |=> standby_o.pwm ==
		$past(bus_i.wdata[PDC_PWM_BIT])) else $error("pulse-width standby wrong");

	// Idle bus reads back zero, so stale data never lingers
	rdata_idle_a: assert property (!bus_i.rd
		|=> rdata_o == 32'h0000_0000) else $error("read data lingered");
	reserved_zero_a: assert property (bus_i.rd && bus_i.addr == PDC_OFF_MSB1
		|=> rdata_o[7] == 1'b0 && rdata_o[2] == 1'b0) else $error("reserved bit set");
	reserved_two_a: assert property (bus_i.rd && bus_i.addr == PDC_OFF_MSB2
		|=> rdata_o[6:5] == 2'h0 && rdata_o[3:2] == 2'h0) else $error("reserved pair set");
	wdog_run_a: assert property (wdog_int_osc_i |-> !standby_o.watchdog)
		else $error("watchdog held on internal oscillator");

endmodule

`default_nettype wire

//--- tb/pdc_power_clock_tb_top.sv
// Self-checking testbench for the power-down and clock-select block.
`timescale 1ns/1ps
`default_nettype none

module pdc_power_clock_tb_top;
	import pdc_pkg::*;

	// Design inputs, outputs and bench bookkeeping
	logic         mclk_i;
	logic         rst_n_i;
	pdc_bus_req_t bus_i;
	logic [31:0]  rdata_o;
	logic         sleep_exec_i;
	logic         irq_wake_i;
	logic         wdog_int_osc_i;
	pdc_mode_t    mode_o;
	logic         cpu_halt_o;
	logic         clk_en_o;
	logic         main_osc_on_o;
	logic [2:0]   act_log2_o;
	logic [2:0]   sub_log2_o;
	pdc_standby_t standby_o;
	int           fail_count = 0;
	int           tests_run = 0;
	int           cycles = 0;
	logic [2:0]   exp_act;
	logic [2:0]   exp_sub;
	logic [9:0]   exp_sb;
	logic [7:0]   b;

	pdc_power_clock pdc_power_clock_i (
		.mclk_i        (mclk_i),
		.rst_n_i       (rst_n_i),
		.bus_i         (bus_i),
		.rdata_o       (rdata_o),
		.sleep_exec_i  (sleep_exec_i),
		.irq_wake_i    (irq_wake_i),
		.wdog_int_osc_i(wdog_int_osc_i),
		.mode_o        (mode_o),
		.cpu_halt_o    (cpu_halt_o),
		.clk_en_o      (clk_en_o),
		.main_osc_on_o (main_osc_on_o),
		.act_log2_o    (act_log2_o),
		.sub_log2_o    (sub_log2_o),
		.standby_o     (standby_o)
	);

	// 25 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge mclk_i) begin
		cycles = cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask

	// One-cycle write strobe; a gap cycle follows before the next call
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_i);
		bus_i.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge mclk_i);
		bus_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_i);
		bus_i.rd <= 1'b0;
		#1 chk(rdata_o, exp);
	endtask

	// Cycles between two divided-clock pulses
	task automatic gap(input int n);
		int k;
		k = 0;
		while (clk_en_o !== 1'b1 && k < 200) begin
			@(posedge mclk_i);
			#1 k++;
		end
		k = 0;
		do begin
			@(posedge mclk_i);
			#1 k++;
		end while (clk_en_o !== 1'b1 && k < 200);
		chk(k, n);
	endtask

	// Program, check old dividers still live, sleep, then wake
	task automatic step(input logic [7:0] pm, input logic [7:0] sc,
			input pdc_mode_t es, input pdc_mode_t ew);
		wr(PDC_OFF_PMCC, {24'h0000_00, pm});
		wr(PDC_OFF_SYSC, {24'h0000_00, sc});
		#1 chk({29'h0, act_log2_o}, {29'h0, exp_act});
		chk({29'h0, sub_log2_o}, {29'h0, exp_sub});
		exp_act = pm[4] ? {1'b0, pm[3:2]} + 3'h3 : 3'h0;
		exp_sub = pm[1] ? 3'h1 : (pm[0] ? 3'h2 : 3'h3);
		@(posedge mclk_i);
		sleep_exec_i <= 1'b1;
		@(posedge mclk_i);
		sleep_exec_i <= 1'b0;
		#1 chk({29'h0, mode_o}, {29'h0, es});
		chk({31'h0, cpu_halt_o}, {31'h0, es == PDC_SLEEP || es == PDC_SUBSLEEP || es == PDC_STANDBY});
		chk({31'h0, main_osc_on_o}, {31'h0, es == PDC_ACTIVE || es == PDC_SLEEP});
		chk({29'h0, act_log2_o}, {29'h0, exp_act});
		chk({29'h0, sub_log2_o}, {29'h0, exp_sub});
		// Halted clock must stay quiet for a good while in standby
		if (es == PDC_STANDBY)
			repeat (70) begin
				@(posedge mclk_i);
				#1 chk({31'h0, clk_en_o}, 32'h0000_0000);
			end
		@(posedge mclk_i);
		irq_wake_i <= 1'b1;
		@(posedge mclk_i);
		irq_wake_i <= 1'b0;
		#1 chk({29'h0, mode_o}, {29'h0, ew});
	endtask

	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		bus_i = '0;
		sleep_exec_i = 1'b0;
		irq_wake_i = 1'b0;
		wdog_int_osc_i = 1'b0;
		exp_act = 3'h0;
		exp_sub = 3'h3;
		repeat (3) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		#1 chk({29'h0, mode_o}, {29'h0, PDC_ACTIVE});
		chk({22'h0, standby_o}, 32'h0000_0000);
		rd(PDC_OFF_PMCC, 32'h0000_0000);
		rd(PDC_OFF_MSB1, 32'h0000_0000);
		rd(PDC_OFF_MSB2, 32'h0000_0000);
		// Walk a single one through both standby registers, with and without the oscillator
		for (int o = 0; o < 2; o++) begin
			@(posedge mclk_i);
			wdog_int_osc_i <= o[0];
			for (int i = 0; i < 8; i++) begin
				b = 8'h01 << i;
				wr(PDC_OFF_MSB1, {24'h0000_00, b});
				wr(PDC_OFF_MSB2, {24'h0000_00, b});
				exp_sb = {b[6], b[5], b[4], b[3] & ~o[0], b[1], b[0], b[7], b[4], b[1], b[0]};
				#1 chk({22'h0, standby_o}, {22'h0, exp_sb});
				rd(PDC_OFF_MSB1, {24'h0000_00, b & 8'h7B});
				rd(PDC_OFF_MSB2, {24'h0000_00, b & 8'h93});
			end
		end
		// Unmapped place ignores writes and reads zero
		wr(8'h14, 32'hFFFF_FFFF);
		rd(8'h14, 32'h0000_0000);
		// Every divider code, each taking effect only at a sleep
		for (int i = 0; i < 8; i++) begin
			step({3'h0, i[2:0], i[1:0]}, 8'h00, PDC_SLEEP, PDC_ACTIVE);
			rd(PDC_OFF_PMCC, {27'h0, i[2:0], i[1:0]});
			gap(1 << exp_act);
		end
		// Mode table, including direct transfer and standby
		step(8'h40, 8'h00, PDC_SLEEP, PDC_SUBACTIVE);
		rd(PDC_OFF_STAT, {29'h0, PDC_SUBACTIVE});
		step(8'h20, 8'h00, PDC_ACTIVE, PDC_ACTIVE);
		step(8'h80, 8'h00, PDC_SUBSLEEP, PDC_ACTIVE);
		step(8'hC0, 8'h00, PDC_SUBSLEEP, PDC_SUBACTIVE);
		step(8'h60, 8'h80, PDC_SUBACTIVE, PDC_SUBACTIVE);
		step(8'h20, 8'h80, PDC_ACTIVE, PDC_ACTIVE);
		rd(PDC_OFF_SYSC, 32'h0000_0080);
		step(8'h40, 8'h80, PDC_STANDBY, PDC_ACTIVE);
		wrap_up();
	end

endmodule

`default_nettype wire
